//--- cdt_pkg.sv
package cdt_pkg;

  // clock and time base
  localparam int CLK_PERIOD_NS  = 40;
  localparam int STAGGER_US     = 62500;   // 62.5 ms between channel edges
  localparam int STAGGER_CYCLES = STAGGER_US * 1000 / CLK_PERIOD_NS;
  localparam int TICK_W         = 21;

  // every slow time is counted in stagger ticks
  localparam int PWM_PERIOD_MS  = 30000;
  localparam int PWM_STEP_MS    = 2000;
  localparam int WDT_MS         = 2000;
  localparam int MON_PERIOD_MS  = 30000;
  localparam int HALF_MIN_MS    = 30000;
  localparam int PWM_PERIOD_TICKS = PWM_PERIOD_MS * 1000 / STAGGER_US;
  localparam int PWM_STEP_TICKS   = PWM_STEP_MS * 1000 / STAGGER_US;
  localparam int WDT_TICKS        = WDT_MS * 1000 / STAGGER_US;
  localparam int MON_TICKS        = MON_PERIOD_MS * 1000 / STAGGER_US;
  localparam int HALF_MIN_TICKS   = HALF_MIN_MS * 1000 / STAGGER_US;

  localparam int NCH = 18;

  // register offsets (byte addresses on the 8-bit register port)
  localparam logic [7:0] ADDR_CFGA   = 8'h00;  // 6 bytes
  localparam logic [7:0] ADDR_CFGB   = 8'h06;  // 2 bytes
  localparam logic [7:0] ADDR_PWM    = 8'h08;  // 9 bytes
  localparam logic [7:0] ADDR_SWGRP  = 8'h11;  // 9 bytes
  localparam logic [7:0] ADDR_STATUS = 8'h1a;
  localparam logic [7:0] ADDR_COMMIT = 8'h1b;
  localparam int CFGA_N  = 6;
  localparam int CFGB_N  = 2;
  localparam int PWM_N   = 9;
  localparam int SWGRP_N = 9;

  // field positions and reset values
  localparam int TMO_LSB       = 4;        // in config A byte 5
  localparam int MON_EN_BIT    = 3;        // in config B byte 1
  localparam int COMMIT_BIT    = 0;
  localparam logic [7:0] CFG_RST    = 8'h00;
  localparam logic [7:0] SWGRP_RST  = 8'h00;
  localparam logic [7:0] PWM_RST    = 8'hff;
  localparam logic [7:0] GPIO_MASK  = 8'h0f; // gpio bits of config B byte 0
  localparam logic [1:0] CONV_NORMAL_7K = 2'h1;

  // timeout code to length in half minutes
  function automatic logic [7:0] timeout_half_min(input logic [3:0] code);
    case (code)
      4'h1: timeout_half_min = 8'h01;
      4'h2: timeout_half_min = 8'h02;
      4'h3: timeout_half_min = 8'h04;
      4'h4: timeout_half_min = 8'h06;
      4'h5: timeout_half_min = 8'h08;
      4'h6: timeout_half_min = 8'h0a;
      4'h7: timeout_half_min = 8'h14;
      4'h8: timeout_half_min = 8'h1e;
      4'h9: timeout_half_min = 8'h28;
      4'ha: timeout_half_min = 8'h3c;
      4'hb: timeout_half_min = 8'h50;
      4'hc: timeout_half_min = 8'h78;
      4'hd: timeout_half_min = 8'h96;
      4'he: timeout_half_min = 8'hb4;
      4'hf: timeout_half_min = 8'hf0;
      default: timeout_half_min = 8'h00;
    endcase
  endfunction

  typedef enum logic {MON_IDLE, MON_WAIT} mon_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_s;

  typedef struct packed {
    logic           done;
    logic           redund_fail;
    logic [NCH-1:0] uv;
  } mon_result_s;

  typedef struct packed {
    logic                      en_pin_meta;
    logic                      en_pin_sync;
    logic [TICK_W-1:0]         tick_cnt;
    logic [5:0]                wdt_cnt;
    logic                      wdt_exp;
    logic [16:0]               dt_remain;
    logic [CFGA_N-1:0][7:0]    cfga;
    logic [CFGA_N-1:0][7:0]    stage;
    logic [CFGB_N-1:0][7:0]    cfgb;
    logic [PWM_N-1:0][7:0]     pwm;
    logic [SWGRP_N-1:0][7:0]   swgrp;
    mon_state_e                mon;
    logic [8:0]                mon_cnt;
    logic                      conv_req;
    logic [NCH-1:0]            s_out;
    logic [7:0]                rd_data;
  } core_state_s;

  typedef struct packed {
    logic [8:0]     phase;
    logic [NCH-1:0] on;
  } pwm_state_s;

endpackage

//--- pwm_stagger.sv
`timescale 1ns/1ps
module pwm_stagger (
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  input  wire logic                      tick,
  input  wire logic [4*cdt_pkg::NCH-1:0] codes,
  output logic      [cdt_pkg::NCH-1:0]   pwm_on
);

  localparam logic [8:0] PERIOD =
    9'(cdt_pkg::PWM_PERIOD_TICKS);
  localparam logic [8:0] STEP = 9'(cdt_pkg::PWM_STEP_TICKS);

  cdt_pkg::pwm_state_s r;
  cdt_pkg::pwm_state_s n;
  logic [cdt_pkg::NCH-1:0] on_w;

  // channel k sees the shared phase shifted by k stagger ticks, so every
  // channel turns on at its own tick and no two edges coincide
  genvar k;
  generate
    for (k = 0; k < cdt_pkg::NCH; k++) begin : g_ch
      logic [8:0] ph;
      logic [3:0] code;
      assign code = codes[4*k +: 4];
      assign ph = (r.phase >= 9'(k)) ? r.phase - 9'(k)
                                     : 9'(r.phase + PERIOD - 9'(k));
      assign on_w[k] = (code == 4'hf) ? 1'b1
                     : (ph < 9'(code * STEP));
    end
  endgenerate

  // one phase counter for all channels, fixed 30 s period
  always_comb begin
    n = r;
    if (tick) begin
      n.phase = (r.phase == PERIOD - 9'h001) ? 9'h000
                                             : r.phase + 9'h001;
    end
    n.on = on_w;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign pwm_on = r.on;

endmodule

//--- cell_discharge_timer_pwm.sv
`timescale 1ns/1ps
module cell_discharge_timer_pwm #(
  parameter int TICK_CYCLES = cdt_pkg::STAGGER_CYCLES
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  input  wire cdt_pkg::bus_req_s       bus,
  output logic      [7:0]              rd_data,
  input  wire logic                    valid_cmd,
  input  wire logic                    wake_evt,
  input  wire logic                    sleep_enter,
  input  wire logic                    thermal_evt,
  input  wire logic                    discharge_timer_enable_pin,
  input  wire cdt_pkg::mon_result_s    mon_res,
  output logic                         conv_req,
  output logic      [1:0]              conv_mode,
  output logic      [cdt_pkg::NCH-1:0] s_out,
  output logic                         wdt_expired,
  output logic                         dt_active
);

  generate
    if (TICK_CYCLES < 2 || TICK_CYCLES > (1 << cdt_pkg::TICK_W)) begin : g_chk
      $error("TICK_CYCLES out of range for tick counter");
    end
  endgenerate

  localparam logic [cdt_pkg::TICK_W-1:0] TICK_LAST =
    cdt_pkg::TICK_W'(TICK_CYCLES - 1);
  localparam logic [5:0]  WDT_LIMIT = 6'(cdt_pkg::WDT_TICKS);
  localparam logic [8:0]  MON_LAST  = 9'(cdt_pkg::MON_TICKS - 1);
  localparam logic [16:0] HALF_MIN  = 17'(cdt_pkg::HALF_MIN_TICKS);

  cdt_pkg::core_state_s r;
  cdt_pkg::core_state_s n;
  logic [cdt_pkg::NCH-1:0] pwm_on;
  logic                    tick;

  // length of a timeout code in ticks
  function automatic logic [16:0] code_ticks(input logic [3:0] code);
    code_ticks = 17'(cdt_pkg::timeout_half_min(code) * HALF_MIN);
  endfunction

  // smallest code whose length still covers the remaining time
  function automatic logic [3:0] remain_bucket(input logic [16:0] rem);
    logic [3:0] code;
    code = 4'h0;
    for (int k = 15; k >= 1; k--) begin
      if (rem != 17'h00000 && rem <= code_ticks(4'(k))) begin
        code = 4'(k);
      end
    end
    remain_bucket = code;
  endfunction

  // discharge bits are scattered over config A and B
  function automatic logic [cdt_pkg::NCH-1:0] get_discharge(
    input logic [cdt_pkg::CFGA_N-1:0][7:0] a,
    input logic [cdt_pkg::CFGB_N-1:0][7:0] b);
    get_discharge = {b[1][1:0], b[0][7:4], a[5][3:0], a[4]};
  endfunction

  // one-cycle enable per stagger interval; every slow time rides on it,
  // so a shorter divider speeds up the whole block in proportion
  assign tick = (r.tick_cnt == TICK_LAST);

  // duty codes travel as one flat vector, low nibble of byte 0 is cell 1
  pwm_stagger u_pwm (
    .sys_clk (sys_clk),
    .rst     (rst),
    .tick    (tick),
    .codes   (r.pwm),
    .pwm_on  (pwm_on)
  );

  always_comb begin
    logic                    commit;
    logic                    wdt_fire;
    logic                    dt_fire;
    logic                    timer_on;
    logic                    mon_run;
    logic [cdt_pkg::NCH-1:0] dis_bits;
    logic [7:0]              idx;
    logic [7:0]              rv;
    commit   = 1'b0;
    wdt_fire = 1'b0;
    dt_fire  = 1'b0;
    timer_on = 1'b0;
    mon_run  = 1'b0;
    dis_bits = '0;
    idx      = 8'h00;
    rv       = 8'h00;
    n = r;
    n.conv_req = 1'b0;

    // pin synchroniser, second stage is the only reader of the first
    n.en_pin_meta = discharge_timer_enable_pin;
    n.en_pin_sync = r.en_pin_meta;

    // free running stagger tick divider
    n.tick_cnt = tick ? '0 : r.tick_cnt + 1'b1;

    commit = bus.wr && bus.addr == cdt_pkg::ADDR_COMMIT &&
             bus.wdata[cdt_pkg::COMMIT_BIT];

    // watchdog: restarted by valid commands, wake and commit, fires past 2 s
    if (valid_cmd || wake_evt || commit) begin
      n.wdt_cnt = 6'h00;
      n.wdt_exp = 1'b0;
    end else if (tick && !r.wdt_exp) begin
      if (r.wdt_cnt == WDT_LIMIT) begin
        n.wdt_exp = 1'b1;
        wdt_fire  = 1'b1;
      end else begin
        n.wdt_cnt = r.wdt_cnt + 6'h01;
      end
    end

    // discharge timer counts down; ordinary commands leave it alone
    timer_on = (r.dt_remain != 17'h00000);
    if (!r.en_pin_sync) begin
      n.dt_remain = 17'h00000;
    end else if (tick && timer_on) begin
      n.dt_remain = r.dt_remain - 17'h00001;
      dt_fire     = (r.dt_remain == 17'h00001);
    end

    // expiry resets act this cycle; a register write in the same cycle is applied after them and wins
    if (wdt_fire) begin
      for (int i = 0; i < 4; i++) begin
        n.cfga[i] = cdt_pkg::CFG_RST;
      end
      n.cfgb[0] = (n.cfgb[0] & ~cdt_pkg::GPIO_MASK) |
                  (cdt_pkg::CFG_RST & cdt_pkg::GPIO_MASK);
      if (!timer_on) begin
        n.cfga[4] = cdt_pkg::CFG_RST;
        n.cfga[5] = cdt_pkg::CFG_RST;
        n.cfgb    = {cdt_pkg::CFGB_N{cdt_pkg::CFG_RST}};
        n.swgrp   = {cdt_pkg::SWGRP_N{cdt_pkg::SWGRP_RST}};
      end
    end
    if (dt_fire) begin
      n.cfga[4] = cdt_pkg::CFG_RST;
      n.cfga[5] = cdt_pkg::CFG_RST;
      n.swgrp   = {cdt_pkg::SWGRP_N{cdt_pkg::SWGRP_RST}};
      n.cfgb[1] = cdt_pkg::CFG_RST;
      n.cfgb[0] = (n.cfgb[0] & cdt_pkg::GPIO_MASK) |
                  (cdt_pkg::CFG_RST & ~cdt_pkg::GPIO_MASK);
    end

    // overheating puts config A, config B and switch groups back to defaults, switches the timer off
    if (thermal_evt) begin
      n.cfga      = {cdt_pkg::CFGA_N{cdt_pkg::CFG_RST}};
      n.cfgb      = {cdt_pkg::CFGB_N{cdt_pkg::CFG_RST}};
      n.swgrp     = {cdt_pkg::SWGRP_N{cdt_pkg::SWGRP_RST}};
      n.dt_remain = 17'h00000;
    end

    if (sleep_enter) begin
      n.pwm = {cdt_pkg::PWM_N{cdt_pkg::PWM_RST}};
    end

    // monitor: a normal mode conversion every 30 s while balancing alone
    mon_run = r.cfgb[1][cdt_pkg::MON_EN_BIT] && r.wdt_exp && timer_on;
    case (r.mon)
      cdt_pkg::MON_IDLE: begin
        if (!mon_run) begin
          n.mon_cnt = 9'h000;
        end else if (tick) begin
          if (r.mon_cnt == MON_LAST) begin
            n.mon_cnt  = 9'h000;
            n.conv_req = 1'b1;
            n.mon      = cdt_pkg::MON_WAIT;
          end else begin
            n.mon_cnt = r.mon_cnt + 9'h001;
          end
        end
      end
      cdt_pkg::MON_WAIT: begin
        if (mon_res.done) begin
          n.mon = cdt_pkg::MON_IDLE;
          // start from this cycle's next values so an expiry reset stays
          dis_bits = get_discharge(n.cfga, n.cfgb);
          if (mon_res.redund_fail) begin
            dis_bits = '0;
          end else begin
            dis_bits = dis_bits & ~mon_res.uv;
          end
          n.cfga[4]      = dis_bits[7:0];
          n.cfga[5][3:0] = dis_bits[11:8];
          n.cfgb[0][7:4] = dis_bits[15:12];
          n.cfgb[1][1:0] = dis_bits[17:16];
        end
      end
      default: n.mon = cdt_pkg::MON_IDLE;
    endcase

    // register writes; config A goes to a staging copy until commit
    if (bus.wr) begin
      if (bus.addr < cdt_pkg::ADDR_CFGB) begin
        idx = bus.addr - cdt_pkg::ADDR_CFGA;
        n.stage[idx[2:0]] = bus.wdata;
      end else if (bus.addr < cdt_pkg::ADDR_PWM) begin
        idx = bus.addr - cdt_pkg::ADDR_CFGB;
        n.cfgb[idx[0]] = bus.wdata;
      end else if (bus.addr < cdt_pkg::ADDR_SWGRP) begin
        idx = bus.addr - cdt_pkg::ADDR_PWM;
        n.pwm[idx[3:0]] = bus.wdata;
      end else if (bus.addr < cdt_pkg::ADDR_STATUS) begin
        idx = bus.addr - cdt_pkg::ADDR_SWGRP;
        n.swgrp[idx[3:0]] = bus.wdata;
      end
    end

    // commit lands after any expiry reset so the new data survive
    if (commit) begin
      n.cfga = r.stage;
      // a zero code or a low pin leaves the timer off after the copy
      n.dt_remain = r.en_pin_sync ?
        code_ticks(r.stage[5][cdt_pkg::TMO_LSB +: 4])
        : 17'h00000;
    end

    // switch pins: direct control, then gated by PWM after expiry while the timer runs, all off when it is not
    // pins lag the registers by one cycle; the stagger lives in pwm_on,
    // so gating here never lines two channel edges up
    dis_bits = get_discharge(r.cfga, r.cfgb);
    if (!r.wdt_exp) begin
      n.s_out = dis_bits;
    end else begin
      n.s_out = timer_on ? (dis_bits & pwm_on) : '0;
    end

    // read data: live registers, timeout field shows time left
    if (bus.rd) begin
      if (bus.addr < cdt_pkg::ADDR_CFGB) begin
        idx = bus.addr - cdt_pkg::ADDR_CFGA;
        rv  = r.cfga[idx[2:0]];
        if (idx == 8'h05) begin
          // stored code is kept for the next commit, only the view changes
          rv[cdt_pkg::TMO_LSB +: 4] = remain_bucket(r.dt_remain);
        end
      end else if (bus.addr < cdt_pkg::ADDR_PWM) begin
        idx = bus.addr - cdt_pkg::ADDR_CFGB;
        rv  = r.cfgb[idx[0]];
      end else if (bus.addr < cdt_pkg::ADDR_SWGRP) begin
        idx = bus.addr - cdt_pkg::ADDR_PWM;
        rv  = r.pwm[idx[3:0]];
      end else if (bus.addr < cdt_pkg::ADDR_STATUS) begin
        idx = bus.addr - cdt_pkg::ADDR_SWGRP;
        rv  = r.swgrp[idx[3:0]];
      end else if (bus.addr == cdt_pkg::ADDR_STATUS) begin
        // status shows the synchronised pin, not the raw level
        rv = {4'h0, r.mon == cdt_pkg::MON_WAIT, r.en_pin_sync,
              timer_on, r.wdt_exp};
      end
    end
    n.rd_data = rv;                                         // one cycle only
  end

  // the whole state in one register; defaults put duty codes at all ones
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      r       <= '0;
      r.cfga  <= {cdt_pkg::CFGA_N{cdt_pkg::CFG_RST}};
      r.stage <= {cdt_pkg::CFGA_N{cdt_pkg::CFG_RST}};
      r.cfgb  <= {cdt_pkg::CFGB_N{cdt_pkg::CFG_RST}};
      r.pwm   <= {cdt_pkg::PWM_N{cdt_pkg::PWM_RST}};
      r.swgrp <= {cdt_pkg::SWGRP_N{cdt_pkg::SWGRP_RST}};
      r.mon   <= cdt_pkg::MON_IDLE;
    end else begin
      r <= n;
    end
  end

  assign rd_data     = r.rd_data;
  assign conv_req    = r.conv_req;
  assign conv_mode   = cdt_pkg::CONV_NORMAL_7K;
  assign s_out       = r.s_out;
  assign wdt_expired = r.wdt_exp;
  assign dt_active   = (r.dt_remain != 17'h00000);

endmodule

//--- cdt_monitor.sv
`timescale 1ns/1ps
module cdt_monitor #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic                    sys_clk,
  input wire logic                    rst,
  input wire cdt_pkg::bus_req_s       bus,
  input wire logic [7:0]              rd_data,
  input wire logic                    valid_cmd,
  input wire logic                    wake_evt,
  input wire logic                    discharge_timer_enable_pin,
  input wire cdt_pkg::mon_result_s    mon_res,
  input wire logic                    conv_req,
  input wire logic [1:0]              conv_mode,
  input wire logic [cdt_pkg::NCH-1:0] s_out,
  input wire logic                    wdt_expired,
  input wire logic                    dt_active
);
  localparam int WLO = 32 * TICK_CYCLES - 2;
  localparam int WHI = 33 * TICK_CYCLES + 2;
  int   quiet_r;
  logic restart;

  // tick phase is free running, so expiry lands anywhere in one tick
  assign restart = valid_cmd | wake_evt
    | (bus.wr & (bus.addr == cdt_pkg::ADDR_COMMIT) & bus.wdata[0]);

  // cycles since the last watchdog restart, saturating
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      quiet_r <= 0;
    end else if (restart) begin
      quiet_r <= 0;
    end else if (quiet_r < 100000) begin
      quiet_r <= quiet_r + 1;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_mode_normal: assert property (conv_mode == 2'h1)
    else $error("conversion mode is not normal");
  a_rd_idle_zero: assert property (!$past(bus.rd) |-> rd_data == 8'h00)
    else $error("read data outside the answer cycle");
  a_conv_when_expired: assert property (conv_req |->
    $past(wdt_expired) && $past(dt_active))
    else $error("conversion asked without expiry");
  a_conv_single: assert property (conv_req |=> !conv_req [*8])
    else $error("conversion request repeated");
  a_wdt_window: assert property ($rose(wdt_expired) |->
    quiet_r >= WLO && quiet_r <= WHI)
    else $error("watchdog expired at wrong time");
  a_wdt_late: assert property (quiet_r == WHI + 1 |-> wdt_expired)
    else $error("watchdog failed to expire");
  a_restart_clears: assert property ((valid_cmd || wake_evt) |=>
    !wdt_expired)
    else $error("watchdog not restarted");
  a_uv_clears: assert property ((mon_res.done && !mon_res.redund_fail)
    |-> ##2 (s_out & $past(mon_res.uv, 2)) == '0)
    else $error("undervoltage cell still switched");
  a_redund_clears: assert property ((mon_res.done && mon_res.redund_fail)
    |-> ##2 s_out == '0)
    else $error("switches left on after check failure");
  a_pin_low_off: assert property (!discharge_timer_enable_pin [*4]
    |-> ##2 !dt_active)
    else $error("timer active with enable pin low");
  a_one_switch: assert property ((wdt_expired && $past(wdt_expired, 2)
    && dt_active && $past(dt_active, 2) && !$past(bus.wr)
    && !$past(bus.wr, 2) && !$past(mon_res.done)
    && !$past(mon_res.done, 2)) |-> $countones(s_out ^ $past(s_out)) <= 1)
    else $error("two switches changed together");
endmodule

bind cell_discharge_timer_pwm cdt_monitor #(.TICK_CYCLES(TICK_CYCLES))
  i_cdt_monitor (
  .sys_clk                    (sys_clk),
  .rst                        (rst),
  .bus                        (bus),
  .rd_data                    (rd_data),
  .valid_cmd                  (valid_cmd),
  .wake_evt                   (wake_evt),
  .discharge_timer_enable_pin (discharge_timer_enable_pin),
  .mon_res                    (mon_res),
  .conv_req                   (conv_req),
  .conv_mode                  (conv_mode),
  .s_out                      (s_out),
  .wdt_expired                (wdt_expired),
  .dt_active                  (dt_active)
);

//--- conv_model.sv
`timescale 1ns/1ps
module conv_model #(
  parameter int LAT = 3
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  input  wire logic                    conv_req,
  input  wire logic [cdt_pkg::NCH-1:0] uv_set,
  input  wire logic                    fail_set,
  output cdt_pkg::mon_result_s         mon_res
);
  int cnt_r;

  // result flags are only meaningful with done; between results they
  // toggle so a design reading them at other times is caught
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_r   <= 0;
      mon_res <= '0;
    end else begin
      mon_res.done        <= (cnt_r == 1);
      mon_res.redund_fail <= (cnt_r == 1) ? fail_set : ~mon_res.redund_fail;
      mon_res.uv          <= (cnt_r == 1) ? uv_set : ~mon_res.uv;
      if (conv_req) begin
        cnt_r <= LAT;
      end else if (cnt_r != 0) begin
        cnt_r <= cnt_r - 1;
      end
    end
  end
endmodule

//--- tb_cell_discharge_timer_pwm.sv
`timescale 1ns/1ps
module tb_cell_discharge_timer_pwm;
  localparam int TC     = 4;
  localparam int PERIOD = 480 * TC;  // one pwm period in cycles
  logic                 sys_clk, rst, valid_cmd, wake_evt, sleep_enter;
  logic                 dt_pin, fail_set, conv_req, wdt_expired, dt_active;
  cdt_pkg::bus_req_s    bus;
  cdt_pkg::mon_result_s mon_res;
  logic [7:0]           rd_data;
  logic [1:0]           conv_mode;
  logic [17:0]          s_out, uv_set, prev;
  int                   failures, n_compared, on0, on1, on4, on12, r1, r3;

  cell_discharge_timer_pwm #(.TICK_CYCLES(TC)) i_cell_discharge_timer_pwm (
    .sys_clk                    (sys_clk),
    .rst                        (rst),
    .bus                        (bus),
    .rd_data                    (rd_data),
    .valid_cmd                  (valid_cmd),
    .wake_evt                   (wake_evt),
    .sleep_enter                (sleep_enter),
    .thermal_evt                (1'b0),
    .discharge_timer_enable_pin (dt_pin),
    .mon_res                    (mon_res),
    .conv_req                   (conv_req),
    .conv_mode                  (conv_mode),
    .s_out                      (s_out),
    .wdt_expired                (wdt_expired),
    .dt_active                  (dt_active)
  );

  // slow answer, so the request and the result never share a cycle
  conv_model #(.LAT(5)) i_conv_model (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .conv_req (conv_req),
    .uv_set   (uv_set),
    .fail_set (fail_set),
    .mon_res  (mon_res)
  );

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // one-cycle strobe, released on the next edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1;
    chk({24'h0, rd_data}, {24'h0, exp});
  endtask

  task automatic pulse(input int sel);
    @(posedge sys_clk);
    case (sel)
      0: sleep_enter <= 1'b1;
      1: wake_evt <= 1'b1;
      default: valid_cmd <= 1'b1;
    endcase
    @(posedge sys_clk);
    sleep_enter <= 1'b0;
    wake_evt <= 1'b0;
    valid_cmd <= 1'b0;
  endtask

  // 0: watchdog expired, 1: conversion result, 2: timer ended
  task automatic wait_ev(input int sel, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge sys_clk);
      #1;
      if ((sel == 0 && wdt_expired === 1'b1) || (sel == 1 &&
          mon_res.done === 1'b1) || (sel == 2 && dt_active === 1'b0)) break;
    end
    if (i == lim) begin
      failures++;
      $display("unexpected at %0t: wait %0d ran out", $time, sel);
      end_of_test();
    end
  endtask

  initial begin
    rst = 1'b1;
    bus = '0;
    valid_cmd = 1'b0;
    wake_evt = 1'b0;
    sleep_enter = 1'b0;
    dt_pin = 1'b0;
    fail_set = 1'b0;
    uv_set = 18'h00004;
    failures = 0;
    n_compared = 0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    rd(cdt_pkg::ADDR_PWM, 8'hff);
    rd(8'h20, 8'h00);
    wr(cdt_pkg::ADDR_PWM, 8'h12);
    pulse(0);
    rd(cdt_pkg::ADDR_PWM, 8'hff);
    $display("test defaults done");
    // timer disabled by the pin: watchdog clears config A, config B and switch groups, not the duty codes
    wr(8'h04, 8'ha5);
    wr(8'h06, 8'h5f);
    wr(8'h07, 8'h09);
    wr(cdt_pkg::ADDR_COMMIT, 8'h01);
    repeat (3) @(posedge sys_clk);
    #1;
    chk({14'h0, s_out}, 32'h150a5);
    wait_ev(0, 300);
    rd(8'h04, 8'h00);
    rd(8'h06, 8'h00);
    rd(8'h07, 8'h00);
    chk({14'h0, s_out}, 32'h0);
    pulse(1);
    #1;
    chk({31'h0, wdt_expired}, 32'h0);
    pulse(2);
    $display("test timer off done");
    // timer on, two minutes, monitoring enabled
    dt_pin <= 1'b1;
    wr(cdt_pkg::ADDR_PWM, 8'h10);
    wr(8'h09, 8'h1f);
    wr(8'h00, 8'h55);
    wr(8'h04, 8'h0f);
    wr(8'h05, 8'h30);
    wr(8'h06, 8'h1f);
    wr(8'h07, 8'h08);
    wr(cdt_pkg::ADDR_COMMIT, 8'h01);
    rd(8'h05, 8'h30);
    wait_ev(0, 300);
    rd(8'h00, 8'h00);
    rd(8'h04, 8'h0f);
    rd(8'h06, 8'h10);
    // one full period of pwm, counting on-cycles and first rises
    {on0, on1, on4, on12, r1, r3} = {32'd0, 32'd0, 32'd0, 32'd0, -32'd1, -32'd1};
    prev = s_out;
    for (int i = 0; i < PERIOD; i++) begin
      @(posedge sys_clk);
      #1;
      on0 += s_out[0];
      on1 += s_out[1];
      on4 += s_out[4];
      on12 += s_out[12];
      if (s_out[1] && !prev[1] && r1 < 0) r1 = i;
      if (s_out[3] && !prev[3] && r3 < 0) r3 = i;
      prev = s_out;
    end
    chk(on0, 0);
    chk(on1, 32 * TC);
    chk(on4, 0);
    chk(on12, PERIOD);
    chk((r3 - r1 + PERIOD) % PERIOD, 2 * TC);
    $display("test pwm done");
    wait_ev(1, 2500);
    rd(8'h04, 8'h0b);
    fail_set <= 1'b1;
    wait_ev(1, 2500);
    rd(8'h04, 8'h00);
    rd(8'h06, 8'h00);
    wait_ev(2, 8000);
    rd(8'h05, 8'h00);
    rd(8'h07, 8'h00);
    $display("test monitor done");
    end_of_test();
  end
endmodule
